// File: hdl/tape_transport_slave_bus.sv
// slave bus logic of one tape transport
// What this block does
// - respond only when select lines match unit address
// - take motion and write commands on set pulse
// - halt stops motion, rewind runs to completion
// - motion delay gate puts preset on read lines
// - record pulse writes presented nine-bit character
// - nine read lines carry character or preset
// - density lines pick 800 or 1600 bpi
// - 144 kHz clock runs while on-line
// - write clock only when loaded, at speed
// - skew window end strobe in nrzi only
// - late track bit flags vertical parity error when writing or in interchange mode
// - marker sensors drive load point, end status
// - rewinding status held through whole rewind
// - present when powered, loaded when tape mounted
// - ready when stopped, settling while decelerating
// - phase encoded status follows top density line
// - attention set on-line, cleared by clear pulses
// - status change pulse on rewind end, line changes
// - write protect when ring is absent
// - interchange mode narrows skew in nrzi, lowers threshold in pe
`timescale 1ns/1ps
`include "tape_slave_params.svh"
module tape_transport_slave_bus
	import tape_slave_pkg::*;
#(
	parameter int ACCEL_CYCLES = `ACCEL_TIME_US * `CLK_MHZ,
	parameter int DECEL_CYCLES = `DECEL_TIME_US * `CLK_MHZ,
	parameter int MT_W         = 20
) (
	input  wire logic       clk_sys,
	input  wire logic       rstn,
	input  wire logic [2:0] unitAddress,
	input  wire logic [2:0] slaveSelect,
	input  wire logic       cmd_forward,
	input  wire logic       cmd_backward,
	input  wire logic       cmd_rewind,
	input  wire logic       cmd_write,
	input  wire logic       command_latch_pulse,
	input  wire logic       haltMotion,
	input  wire logic       motion_delay_gate,
	input  wire logic       accelerate_flag,
	input  wire logic [8:0] write_bits,
	input  wire logic       record_strobe,
	input  wire logic [2:0] density_select,
	input  wire logic       longitudinal_check_strobe,
	input  wire logic       interchange_read_mode,
	input  wire logic       drive_clear_pulse,
	input  wire logic       initialize_all_pulse,
	input  wire logic       unitPowered,
	input  wire logic       unitOnline,
	input  wire logic       tapeLoaded,
	input  wire logic       loadPointSensed,
	input  wire logic       endMarkerSensed,
	input  wire logic       ringAbsent,
	input  wire logic [8:0] headTrackPulse,
	output logic            transportClock,
	output logic            write_timing_clock,
	output logic [8:0]      read_bits,
	output logic            skew_window_done_strobe,
	output logic            vertical_parity_error_pulse,
	output logic            load_point_status,
	output logic            end_marker_status,
	output logic            rewinding_status,
	output logic            unit_present_status,
	output logic            medium_loaded_status,
	output logic            unit_ready_status,
	output logic            settling_status,
	output logic            phase_encoded_status,
	output logic            attention_flag,
	output logic            status_change_pulse,
	output logic            write_protect_status,
	output logic [2:0]      drive_type_bits,
	output logic            statusDriveEnable,
	output logic [8:0]      headWriteBits,
	output logic            headWriteStrobe,
	output logic            lrcWrite,
	output logic            motorForward,
	output logic            motorBackward,
	output logic            motorRewind,
	output logic            readThresholdLow
);
	localparam int SYNC_W = 46;
	localparam int SKEW_CYC = `CYC_UP(`SKEW_NS);
	localparam int SKEW_TIGHT_CYC = `CYC_UP(`SKEW_TIGHT_NS);

	generate
		if (ACCEL_CYCLES < 1 || DECEL_CYCLES < 1 || ACCEL_CYCLES >= (1 << MT_W)
			|| DECEL_CYCLES >= (1 << MT_W))
			$error("motion counts do not fit the timer");
		if (SKEW_CYC >= (1 << `SKEW_W))
			$error("skew window does not fit its counter");
	endgenerate

	function automatic logic rise(input logic cur, input logic prev);
		return cur & ~prev;
	endfunction : rise

	// ****************************************
	// input synchronisers
	// ****************************************
	logic [SYNC_W-1:0] syncA;
	logic [SYNC_W-1:0] syncB;
	logic [SYNC_W-1:0] syncPrev;
	wire  [SYNC_W-1:0] rawIn = {unitAddress, slaveSelect, cmd_forward, cmd_backward,
		cmd_rewind, cmd_write, command_latch_pulse, haltMotion, motion_delay_gate,
		accelerate_flag, write_bits, record_strobe, density_select,
		longitudinal_check_strobe, interchange_read_mode, drive_clear_pulse,
		initialize_all_pulse, unitPowered, unitOnline, tapeLoaded, loadPointSensed,
		endMarkerSensed, ringAbsent, headTrackPulse};

	// data lines pass the same two stages as their strobes, so they stay aligned
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			syncA    <= '0;
			syncB    <= '0;
			syncPrev <= '0;
		end
		else
		begin
			syncA    <= rawIn;
			syncB    <= syncA;
			syncPrev <= syncB;
		end
	end

	logic [2:0] addrS, selS, denS;
	logic [8:0] wbitsS, tracksS, tracksP;
	logic fwdS, bwdS, rewS, wrS, setS, haltS, mdgS, accS, recS, lrcS, irdS;
	logic dclrS, initS, powS, onlineS, loadedS, botS, eotS, ringS;
	logic setP, recP, dclrP, initP, powP, onlineP;
	assign {addrS, selS, fwdS, bwdS, rewS, wrS, setS, haltS, mdgS, accS, wbitsS, recS,
		denS, lrcS, irdS, dclrS, initS, powS, onlineS, loadedS, botS, eotS, ringS,
		tracksS} = syncB;
	assign {setP, recP, dclrP, initP, powP, onlineP, tracksP} = {syncPrev[`SYNC_SET_POS],
		syncPrev[`SYNC_REC_POS], syncPrev[`SYNC_DCLR_POS], syncPrev[`SYNC_INIT_POS],
		syncPrev[`SYNC_POW_POS], syncPrev[`SYNC_ONLINE_POS], syncPrev[8:0]};

	// ****************************************
	// decoding
	// ****************************************
	wire selected  = (selS == addrS) && powS;
	wire setRise   = rise(setS, setP);
	wire latchTake = setRise && selected && onlineS && !haltS;
	wire recRise   = rise(recS, recP);
	wire peMode    = denS[2];
	wire denLow    = (denS[2:1] == `DEN_LOW_PAT);
	wire denHigh   = (denS == `DEN_HIGH_PAT);
	wire stopReq   = haltS || !onlineS;
	wire onRise    = rise(onlineS, onlineP);
	wire onFall    = rise(onlineP, onlineS);
	wire powFall   = rise(powP, powS);
	wire anyTrack  = |(tracksS & ~tracksP);

	// ****************************************
	// motion control
	// ****************************************
	motion_t           state;
	motion_t           next_state;
	logic [MT_W-1:0]   timer;
	logic              dirFwd;
	logic              writeEnabled;
	wire accelDone = (timer == MT_W'(ACCEL_CYCLES - 1));
	wire decelDone = (timer == MT_W'(DECEL_CYCLES - 1));

	always_comb
	begin
		next_state = state;
		unique case (state)
			MOT_IDLE:
				if (latchTake && rewS && !botS)
					next_state = MOT_REWIND;
				else if (latchTake && (fwdS || bwdS))
					next_state = MOT_ACCEL;
			MOT_ACCEL:
				if (stopReq)
					next_state = MOT_DECEL;
				else if (accelDone)
					next_state = MOT_RUN;
			MOT_RUN:
				if (stopReq)
					next_state = MOT_DECEL;
			MOT_DECEL:
				if (decelDone)
					next_state = MOT_IDLE;
			// halt has no say here; only the load point ends a rewind
			MOT_REWIND:
				if (botS)
					next_state = MOT_IDLE;
		endcase
	end

	wire rewindDone = (state == MOT_REWIND) && (next_state == MOT_IDLE);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state        <= MOT_IDLE;
			timer        <= '0;
			dirFwd       <= 1'b1;
			writeEnabled <= 1'b0;
		end
		else
		begin
			state <= next_state;
			timer <= (next_state != state) ? '0 : timer + 1'b1;
			if (latchTake)
			begin
				dirFwd       <= fwdS;
				writeEnabled <= wrS && !ringS;
			end
		end
	end

	// ****************************************
	// clocks toward the controller
	// ****************************************
	wire              wclkRun = powS && onlineS && loadedS && (state == MOT_RUN)
		&& !accS && (denLow || denHigh);
	wire [`DIV_W-1:0] wclkHalf = denHigh ? `DIV_W'(`WCLK_HALF(`BPI_HIGH))
		: `DIV_W'(`WCLK_HALF(`BPI_LOW));

	clock_divider #(.CNT_W(`DIV_W)) u_link_clk (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.enable     (onlineS),
		.halfPeriod (`DIV_W'(`LINK_HALF_CYC)),
		.clkOut     (transportClock)
	);

	clock_divider #(.CNT_W(`DIV_W)) u_write_clk (
		.clk_sys    (clk_sys),
		.rstn       (rstn),
		.enable     (wclkRun),
		.halfPeriod (wclkHalf),
		.clkOut     (write_timing_clock)
	);

	// ****************************************
	// read character assembly and skew window
	// ****************************************
	skew_t              skewState;
	logic [`SKEW_W-1:0] skewCount;
	logic [8:0]         charAcc;
	logic [8:0]         charReg;
	wire [`SKEW_W-1:0] skewLen = irdS && !peMode ? `SKEW_W'(SKEW_TIGHT_CYC)
		: `SKEW_W'(SKEW_CYC);
	wire skewEnd  = (skewCount == skewLen - 1'b1);
	wire lateEdge = (skewState == SK_LATE) && anyTrack;

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			skewState <= SK_IDLE;
			skewCount <= '0;
			charAcc   <= `CHAR_ZERO;
			charReg   <= `CHAR_ZERO;
		end
		else
		begin
			skewCount <= (skewState == SK_IDLE || skewEnd) ? '0 : skewCount + 1'b1;
			unique case (skewState)
				SK_IDLE:
					if (anyTrack)
					begin
						skewState <= SK_OPEN;
						charAcc   <= tracksS & ~tracksP;
					end
				SK_OPEN:
				begin
					charAcc <= charAcc | (tracksS & ~tracksP);
					if (skewEnd)
					begin
						skewState <= SK_LATE;
						charReg   <= charAcc | (tracksS & ~tracksP);
					end
				end
				// a guard of one window length after the close catches late bits
				SK_LATE:
					if (skewEnd)
						skewState <= SK_IDLE;
			endcase
		end
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			read_bits                   <= `CHAR_ZERO;
			skew_window_done_strobe     <= 1'b0;
			vertical_parity_error_pulse <= 1'b0;
			headWriteBits               <= `CHAR_ZERO;
			headWriteStrobe             <= 1'b0;
			lrcWrite                    <= 1'b0;
			status_change_pulse         <= 1'b0;
			readThresholdLow            <= 1'b0;
			drive_type_bits             <= 3'h0;
		end
		else
		begin
			read_bits <= !selected ? `CHAR_ZERO
				: (mdgS ? `MOTION_PRESET : charReg);
			skew_window_done_strobe <= (skewState == SK_OPEN) && skewEnd && !peMode;
			vertical_parity_error_pulse <= lateEdge && (writeEnabled || irdS);
			headWriteStrobe <= recRise && writeEnabled && selected;
			if (recRise && writeEnabled && selected)
			begin
				headWriteBits <= wbitsS;
				lrcWrite      <= lrcS && !peMode;
			end
			status_change_pulse <= rewindDone || onRise || onFall || powFall;
			readThresholdLow    <= irdS && peMode;
			drive_type_bits     <= selected ? `DRIVE_TYPE : 3'h0;
		end
	end

	// per-unit status, released while another unit is addressed
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			load_point_status    <= 1'b0;
			end_marker_status    <= 1'b0;
			rewinding_status     <= 1'b0;
			unit_present_status  <= 1'b0;
			medium_loaded_status <= 1'b0;
			unit_ready_status    <= 1'b0;
			settling_status      <= 1'b0;
			phase_encoded_status <= 1'b0;
			write_protect_status <= 1'b0;
			statusDriveEnable    <= 1'b0;
			motorForward         <= 1'b0;
			motorBackward        <= 1'b0;
			motorRewind          <= 1'b0;
		end
		else
		begin
			statusDriveEnable    <= selected;
			load_point_status    <= selected && botS;
			end_marker_status    <= selected && eotS;
			rewinding_status     <= selected && (state == MOT_REWIND);
			unit_present_status  <= selected;
			medium_loaded_status <= selected && loadedS;
			unit_ready_status    <= selected && onlineS && (state == MOT_IDLE);
			settling_status      <= selected && (state == MOT_DECEL);
			phase_encoded_status <= selected && peMode;
			write_protect_status <= selected && ringS;
			motorForward  <= (state == MOT_ACCEL || state == MOT_RUN) && dirFwd;
			motorBackward <= (state == MOT_ACCEL || state == MOT_RUN) && !dirFwd;
			motorRewind   <= (state == MOT_REWIND);
		end
	end

	// attention: a new on-line edge outranks a clear in the same cycle
	wire attnClear = (rise(dclrS, dclrP) && selected) || (rise(initS, initP) && onlineS);

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			attention_flag <= 1'b0;
		else if (onRise)
			attention_flag <= 1'b1;
		else if (attnClear)
			attention_flag <= 1'b0;
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	property p_select_only;
		(state == MOT_IDLE && next_state != MOT_IDLE) |-> selected && setRise;
	endproperty
	a_select_only: assert property (p_select_only) else $error("start without select");
	property p_halt_stops;
		(haltS && state == MOT_RUN) |=> (state == MOT_DECEL);
	endproperty
	a_halt_stops: assert property (p_halt_stops) else $error("halt ignored");
	property p_rewind_runs;
		(state == MOT_REWIND && !botS) |=> (state == MOT_REWIND);
	endproperty
	a_rewind_runs: assert property (p_rewind_runs) else $error("rewind cut short");
	property p_preset;
		(selected && mdgS) |=> (read_bits == `MOTION_PRESET);
	endproperty
	a_preset: assert property (p_preset) else $error("preset not on read lines");
	property p_wclk_off;
		!wclkRun |=> !write_timing_clock;
	endproperty
	a_wclk_off: assert property (p_wclk_off) else $error("write clock while stopped");
	property p_record;
		(recRise && writeEnabled && selected) |=> headWriteStrobe
			&& (headWriteBits == $past(wbitsS));
	endproperty
	a_record: assert property (p_record) else $error("record lost");
	property p_nrzi_strobe;
		skew_window_done_strobe |-> $past(!peMode);
	endproperty
	a_nrzi_strobe: assert property (p_nrzi_strobe) else $error("strobe in pe mode");
	property p_rws;
		(selected && state == MOT_REWIND) |=> rewinding_status;
	endproperty
	a_rws: assert property (p_rws) else $error("rewind status missing");
	property p_attention;
		onRise |=> attention_flag [*2];
	endproperty
	a_attention: assert property (p_attention) else $error("attention not set");
	property p_ssc;
		(onFall || powFall) |=> status_change_pulse ##1 !status_change_pulse;
	endproperty
	a_ssc: assert property (p_ssc) else $error("status change missing");
	property p_release;
		!selected |=> !unit_present_status && !unit_ready_status && !statusDriveEnable;
	endproperty
	a_release: assert property (p_release) else $error("status held unselected");
	property p_ready;
		(selected && onlineS && state == MOT_IDLE) |=> unit_ready_status;
	endproperty
	a_ready: assert property (p_ready) else $error("ready missing");

	c_rewind: cover property ((state == MOT_REWIND) ##[1:1000] (state == MOT_IDLE));
	c_run: cover property ((state == MOT_RUN) && write_timing_clock);
	c_vpe: cover property (vertical_parity_error_pulse);
	c_strobe: cover property (skew_window_done_strobe);
endmodule : tape_transport_slave_bus

// File: hdl/tape_slave_params.svh
// timing, field and code constants of the tape transport slave port
`ifndef TAPE_SLAVE_PARAMS_SVH
`define TAPE_SLAVE_PARAMS_SVH

`define CLK_MHZ          100
`define CLK_PERIOD_NS    10
`define LINK_CLK_KHZ     144
`define LINK_HALF_CYC    ((`CLK_MHZ * 1000) / (2 * `LINK_CLK_KHZ))
`define TAPE_SPEED_IPS   45
`define BPI_LOW          800
`define BPI_HIGH         1600
`define WCLK_HALF(bpi)   ((`CLK_MHZ * 1000000) / (2 * (bpi) * `TAPE_SPEED_IPS))
`define DEN_LOW_PAT      2'h1
`define DEN_HIGH_PAT     3'h4
`define ACCEL_TIME_US    5000
`define DECEL_TIME_US    5000
`define SKEW_NS          2400
`define SKEW_TIGHT_NS    1600
`define CYC_UP(ns)       (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// arbitrary value, identifies the transport kind
`define DRIVE_TYPE       3'h6
// arbitrary value, coded motion delay preset
`define MOTION_PRESET    9'h0A5
`define CHAR_ZERO        9'h000
`define DIV_W            12
`define SKEW_W           8
// bit positions of single pins in the synchroniser word
`define SYNC_SET_POS     35
`define SYNC_REC_POS     22
`define SYNC_DCLR_POS    16
`define SYNC_INIT_POS    15
`define SYNC_POW_POS     14
`define SYNC_ONLINE_POS  13

`endif

// File: hdl/tape_slave_pkg.sv
// state types of the tape transport slave port
package tape_slave_pkg;
	typedef enum logic [2:0] {MOT_IDLE, MOT_ACCEL, MOT_RUN, MOT_DECEL, MOT_REWIND} motion_t;
	typedef enum logic [1:0] {SK_IDLE, SK_OPEN, SK_LATE} skew_t;
endpackage : tape_slave_pkg

// File: hdl/clock_divider.sv
// square wave generator with run-time half period
`timescale 1ns/1ps
module clock_divider #(
	parameter int CNT_W = 12
) (
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	input  wire logic             enable,
	input  wire logic [CNT_W-1:0] halfPeriod,
	output logic                  clkOut
);
	logic [CNT_W-1:0] count;
	wire              wrap = (count >= halfPeriod - 1'b1);

	generate
		if (CNT_W < 2)
			$error("clock_divider: CNT_W too small");
	endgenerate

	// stopped clock rests low so the far end sees no stray edge
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			count  <= '0;
			clkOut <= 1'b0;
		end
		else if (!enable)
		begin
			count  <= '0;
			clkOut <= 1'b0;
		end
		else if (wrap)
		begin
			count  <= '0;
			clkOut <= ~clkOut;
		end
		else
			count <= count + 1'b1;
	end
endmodule : clock_divider

// File: bench/tape_controller_model.sv
// controller side model: command lines, set pulse, record strobes
`timescale 1ns/1ps
module tape_controller_model #(
	parameter int SPEEDUP = 40
) (
	input  wire logic clk_sys,
	output logic       cmd_forward,
	output logic       cmd_backward,
	output logic       cmd_rewind,
	output logic       cmd_write,
	output logic       command_latch_pulse,
	output logic       haltMotion,
	output logic       accelerate_flag,
	output logic [8:0] write_bits,
	output logic       record_strobe,
	output logic       longitudinal_check_strobe
);
	initial
	begin
		{cmd_forward, cmd_backward, cmd_rewind, cmd_write} = 4'h0;
		{command_latch_pulse, haltMotion, record_strobe} = 3'h0;
		longitudinal_check_strobe = 1'b0;
		accelerate_flag = 1'b1;
		write_bits = 9'h000;
	end
	// command lines settle well before the set edge and hold through it
	task issue(input logic [3:0] c);
		@(negedge clk_sys);
		haltMotion = 1'b0;
		accelerate_flag = 1'b1;
		{cmd_forward, cmd_backward, cmd_rewind, cmd_write} = c;
		repeat (4) @(negedge clk_sys);
		command_latch_pulse = 1'b1;
		repeat (4) @(negedge clk_sys);
		command_latch_pulse = 1'b0;
		repeat (4) @(negedge clk_sys);
		{cmd_forward, cmd_backward, cmd_rewind, cmd_write} = 4'h0;
	endtask : issue
	task at_speed();
		repeat (SPEEDUP) @(negedge clk_sys);
		accelerate_flag = 1'b0;
	endtask : at_speed
	task accel();
		@(negedge clk_sys);
		accelerate_flag = 1'b1;
	endtask : accel
	task stop();
		@(negedge clk_sys);
		haltMotion = 1'b1;
		repeat (5) @(negedge clk_sys);
		haltMotion = 1'b0;
		accelerate_flag = 1'b1;
	endtask : stop
	// one 160 ns record strobe cycle per character, started on a falling edge
	task record_char(input logic [8:0] d, input logic lrc);
		@(negedge clk_sys);
		write_bits = d;
		longitudinal_check_strobe = lrc;
		#80 record_strobe = 1'b1;
		#80 record_strobe = 1'b0;
		// stale data would hide a late capture
		write_bits = ~d;
		longitudinal_check_strobe = 1'b0;
	endtask : record_char
endmodule : tape_controller_model

// File: bench/tape_transport_slave_bus_tb_top.sv
// self-checking bench of the tape transport slave port
`timescale 1ns/1ps
`include "tape_slave_params.svh"
module tape_transport_slave_bus_tb_top;
	logic clk_sys = 1'b0, rstn = 1'b0;
	logic [2:0] unitAddress, slaveSelect, density_select, drive_type_bits;
	logic [8:0] write_bits, headTrackPulse, read_bits, headWriteBits, d;
	logic cmd_forward, cmd_backward, cmd_rewind, cmd_write, command_latch_pulse, haltMotion;
	logic motion_delay_gate, accelerate_flag, record_strobe, longitudinal_check_strobe;
	logic interchange_read_mode, drive_clear_pulse, initialize_all_pulse, unitPowered;
	logic unitOnline, tapeLoaded, loadPointSensed, endMarkerSensed, ringAbsent;
	logic transportClock, write_timing_clock, skew_window_done_strobe;
	logic vertical_parity_error_pulse, load_point_status, end_marker_status;
	logic rewinding_status, unit_present_status, medium_loaded_status, unit_ready_status;
	logic settling_status, phase_encoded_status, attention_flag, status_change_pulse;
	logic write_protect_status, statusDriveEnable, headWriteStrobe, lrcWrite;
	logic motorForward, motorBackward, motorRewind, readThresholdLow;
	logic [9:0] w;
	int n_fail = 0, check_count = 0, n, i;
	assign w = {vertical_parity_error_pulse, skew_window_done_strobe,
		settling_status, rewinding_status, motorForward, write_timing_clock,
		transportClock, unit_ready_status, status_change_pulse, headWriteStrobe};
	always #5 clk_sys = ~clk_sys;
	tape_transport_slave_bus #(.ACCEL_CYCLES(20), .DECEL_CYCLES(20)) u_dut (.*);
	tape_controller_model u_ctl (.clk_sys, .cmd_forward, .cmd_backward, .cmd_rewind,
		.cmd_write, .command_latch_pulse, .haltMotion, .accelerate_flag, .write_bits,
		.record_strobe, .longitudinal_check_strobe);
	task close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out
	task chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task wait_bit(input int b, input logic v, input int lim);
		int k;
		for (k = 0; k < lim && w[b] !== v; k++) @(negedge clk_sys);
		if (k == lim)
		begin
			n_fail++;
			$display("MISMATCH wait bit %0d expected %b seen %b", b, v, w[b]);
			close_out();
		end
	endtask : wait_bit
	// rise to rise, in clk_sys cycles
	task period(input int b, output int p);
		wait_bit(b, 0, 3000);
		wait_bit(b, 1, 3000);
		p = 0;
		do begin @(negedge clk_sys); p++; end while (w[b] !== 0 && p < 6000);
		do begin @(negedge clk_sys); p++; end while (w[b] !== 1 && p < 6000);
	endtask : period
	task settle();
		repeat (6) @(negedge clk_sys);
	endtask : settle
	task pulse_clear(input logic all);
		@(negedge clk_sys);
		if (all) initialize_all_pulse = 1'b1;
		else drive_clear_pulse = 1'b1;
		repeat (4) @(negedge clk_sys);
		{drive_clear_pulse, initialize_all_pulse} = 2'h0;
		settle();
	endtask : pulse_clear
	task online(input logic v);
		@(negedge clk_sys);
		unitOnline = v;
		wait_bit(1, 1, 20);
	endtask : online
	initial
	begin
		void'($urandom(39));
		unitAddress = 3'($urandom);
		slaveSelect = unitAddress;
		density_select = 3'h2;
		{motion_delay_gate, interchange_read_mode, drive_clear_pulse} = 3'h0;
		{initialize_all_pulse, endMarkerSensed, ringAbsent, loadPointSensed} = 4'h0;
		{unitPowered, unitOnline, tapeLoaded} = 3'h7;
		headTrackPulse = 9'h000;
		repeat (16) @(negedge clk_sys);
		rstn = 1'b1;
		settle();
		chk("drive type", drive_type_bits, `DRIVE_TYPE);
		for (i = 0; i < 4; i++)
		begin
			{unitPowered, tapeLoaded, loadPointSensed, endMarkerSensed, ringAbsent} = 5'($urandom);
			settle();
			chk("present", unit_present_status, unitPowered);
			chk("loaded", medium_loaded_status, unitPowered & tapeLoaded);
			chk("load point", load_point_status, unitPowered & loadPointSensed);
			chk("end marker", end_marker_status, unitPowered & endMarkerSensed);
			chk("protect", write_protect_status, unitPowered & ringAbsent);
			chk("ready idle", unit_ready_status, unitPowered);
		end
		{unitPowered, tapeLoaded, loadPointSensed, endMarkerSensed, ringAbsent} = 5'h18;
		settle();
		u_ctl.issue(4'h9);
		wait_bit(5, 1, 20);
		chk("ready moving", unit_ready_status, 1'b0);
		u_ctl.at_speed();
		period(4, n);
		chk("wclk 800", n, 2 * `WCLK_HALF(`BPI_LOW));
		for (i = 0; i < 4; i++)
		begin
			d = 9'($urandom);
			fork
				u_ctl.record_char(d, i == 3);
				wait_bit(0, 1, 30);
			join
			chk("head bits", headWriteBits, d);
			chk("lrc", lrcWrite, i == 3);
		end
		density_select = 3'h4;
		interchange_read_mode = 1'b1;
		period(4, n);
		chk("wclk 1600", n, 2 * `WCLK_HALF(`BPI_HIGH));
		chk("pe", phase_encoded_status, 1'b1);
		chk("low threshold", readThresholdLow, 1'b1);
		u_ctl.accel();
		repeat (1500) @(negedge clk_sys);
		chk("wclk accel", write_timing_clock, 1'b0);
		u_ctl.stop();
		wait_bit(7, 1, 10);
		chk("settling", settling_status, 1'b1);
		wait_bit(2, 1, 60);
		chk("settled", settling_status, 1'b0);
		u_ctl.issue(4'h4);
		chk("backward", motorBackward, 1'b1);
		u_ctl.stop();
		wait_bit(2, 1, 60);
		u_ctl.issue(4'h2);
		wait_bit(6, 1, 20);
		u_ctl.stop();
		chk("rewind on halt", rewinding_status, 1'b1);
		chk("rewind motor", motorRewind, 1'b1);
		loadPointSensed = 1'b1;
		wait_bit(1, 1, 20);
		settle();
		chk("rewind done", rewinding_status, 1'b0);
		motion_delay_gate = 1'b1;
		settle();
		chk("preset", read_bits, `MOTION_PRESET);
		motion_delay_gate = 1'b0;
		// nrzi with interchange on: the tight window must close well before 240 cycles
		density_select = 3'h2;
		d = 9'($urandom) | 9'h100;
		headTrackPulse = d;
		wait_bit(8, 1, 200);
		headTrackPulse = 9'h000;
		@(negedge clk_sys);
		chk("read char", read_bits, d);
		headTrackPulse = 9'h001;
		wait_bit(9, 1, 20);
		headTrackPulse = 9'h000;
		online(1'b0);
		settle();
		chk("clock off", transportClock, 1'b0);
		online(1'b1);
		chk("attention", attention_flag, 1'b1);
		period(3, n);
		chk("clock 144k", n, 2 * `LINK_HALF_CYC);
		pulse_clear(1'b0);
		chk("clear", attention_flag, 1'b0);
		online(1'b0);
		online(1'b1);
		pulse_clear(1'b1);
		chk("init", attention_flag, 1'b0);
		slaveSelect = unitAddress + 3'h1;
		settle();
		chk("released", {statusDriveEnable, unit_present_status, drive_type_bits}, 0);
		u_ctl.issue(4'h8);
		repeat (10) @(negedge clk_sys);
		chk("unselected cmd", motorForward, 1'b0);
		close_out();
	end
	initial
	begin
		#900000;
		n_fail++;
		close_out();
	end
endmodule : tape_transport_slave_bus_tb_top
